/* rtl/fpe_pkg.sv */
package fpe_pkg;

  // ----------------------------------------
  // Register byte offsets on the APB
  // ----------------------------------------
  localparam logic [11:0] FPE_OFS_OVERLAY = 12'h000;  // ram_overlay_control
  localparam logic [11:0] FPE_OFS_CTRL1 = 12'h004;    // flash_control_one
  localparam logic [11:0] FPE_OFS_CTRL2 = 12'h008;    // flash_control_two
  localparam logic [11:0] FPE_OFS_EBS1 = 12'h00C;     // erase_block_select_one
  localparam logic [11:0] FPE_OFS_EBS2 = 12'h010;     // erase_block_select_two
  localparam logic [11:0] FPE_OFS_STATUS = 12'h014;   // operation status
  localparam logic [11:0] FPE_OFS_VADDR = 12'h018;    // latched verify address
  localparam logic [11:0] FPE_OFS_PADDR = 12'h01C;    // latched program address
  localparam logic [11:0] FPE_OFS_EVENT = 12'h020;    // CPU event strobes

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  // ram_overlay_control
  localparam int FPE_OVL_SEL_LSB = 0;   // 3-bit block choice
  localparam int FPE_OVL_SEL_W = 3;
  localparam int FPE_OVL_OVERLAY_SELECT_BIT_BIT = 3;  // overlay_select_bit
  // flash_control_one
  localparam int FPE_C1_P_BIT = 0;      // program enable
  localparam int FPE_C1_E_BIT = 1;      // erase enable
  localparam int FPE_C1_PV_BIT = 2;     // program_verify_bit
  localparam int FPE_C1_EV_BIT = 3;     // erase_verify_bit
  localparam int FPE_C1_SWE_BIT = 6;    // software_write_enable_bit
  localparam int FPE_C1_W = 7;
  // flash_control_two
  localparam int FPE_C2_FLASH_ERROR_FLAG_BIT = 7;   // flash_error_flag
  // event register (strobes in bits 0-2, boot level in bit 3 reads back)
  localparam int FPE_EV_READ_BIT = 0;   // flash read seen
  localparam int FPE_EV_EXC_BIT = 1;    // exception seen
  localparam int FPE_EV_SLEEP_BIT = 2;  // sleep executed
  localparam int FPE_EV_BOOT_BIT = 3;   // boot program running (level)

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] FPE_RST_BYTE = 8'h00;
  localparam logic [31:0] FPE_RST_WORD = 32'h0000_0000;

  // ----------------------------------------
  // Address map
  // ----------------------------------------
  localparam logic [31:0] FPE_OVL_RAM_BASE = 32'hFFFF_D000;
  localparam logic [31:0] FPE_OVL_RAM_LAST = 32'hFFFF_DFFF;
  localparam logic [31:0] FPE_SMALL_BLK_LAST = 32'h0000_7FFF;
  localparam int FPE_BLK_SHIFT = 12;    // 4-kbyte blocks
  localparam int FPE_PROG_UNIT = 128;   // bytes latched per program
  localparam logic [7:0] FPE_PAD_BYTE = 8'hFF;
  localparam logic [7:0] FPE_ALIGN_MASK = 8'h7F;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    FPE_MODE_IDLE,
    FPE_MODE_PROG,
    FPE_MODE_PVER,
    FPE_MODE_ERASE,
    FPE_MODE_EVER
  } fpe_mode_t;

  // One CPU access towards the flash/RAM space
  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] strb;
    logic [31:0] addr;
    logic [31:0] wdata;
  } fpe_mem_req_t;

  // Routed memory access
  typedef struct packed {
    logic to_ram;
    logic [31:0] addr;
  } fpe_route_t;

endpackage

/* rtl/fpe_flash_ctrl.sv */
`timescale 1ns/100ps
// Notes on behaviour
// - Overlay control maps RAM onto flash addresses.
// - Overlay RAM fixed at 4-kbyte window D000-DFFF.
// - Overlay field picks one of eight blocks.
// - Overlay RAM answers at both address ranges.
// - Overlay select blocks program and erase entry.
// - Erase never touches the overlaid RAM.
// - Control bits select one of four modes.
// - Latch start address and data; align 00/80.
// - Program pulse lasts while program bit set.
// - Erase pulse lasts while erase bit set.
// - Verify dummy write FF selects read address.
// - Block all interrupts during program, erase, boot.
// - Protect pin high clears controls, forces protection.
// - Reset or standby clears controls, forces protection.
// - Cleared software enable blocks program and erase entry.
// - Read, exception or sleep during program or erase sets error, aborts.
module fpe_flash_ctrl
  import fpe_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Pins and system levels
  input wire logic write_protect_pin_in,
  input wire logic standby_in,
  input wire logic por_n_in,
  // CPU memory access towards flash and RAM
  input wire fpe_mem_req_t mem_req_in,
  output fpe_route_t route_out,
  // Flash array controls
  output logic prog_pulse_out,
  output logic erase_pulse_out,
  output logic [15:0] erase_blocks_out,
  output logic [7:0] prog_data_out [FPE_PROG_UNIT],
  output logic prog_data_valid_out,
  // Interrupt gate and mode
  input wire logic irq_in,
  input wire logic nmi_in,
  output logic irq_out,
  output logic nmi_out,
  output fpe_mode_t mode_out
);

  // ----------------------------------------
  // Synchronisers for outside levels
  // ----------------------------------------
  logic wp_s1_r;   // Protect pin first stage
  logic wp_s2_r;   // Protect pin usable level
  logic sb_s1_r;   // Standby first stage
  logic sb_s2_r;   // Standby usable level
  logic por_s1_r;  // Power-on reset first stage
  logic por_s2_r;  // Power-on reset usable level (low active)

  // Two flops per level, first flop read only by the second
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      wp_s1_r <= 1'b1;
      wp_s2_r <= 1'b1;
      sb_s1_r <= 1'b0;
      sb_s2_r <= 1'b0;
      por_s1_r <= 1'b0;
      por_s2_r <= 1'b0;
    end
    else
    begin
      wp_s1_r <= write_protect_pin_in;
      wp_s2_r <= wp_s1_r;
      sb_s1_r <= standby_in;
      sb_s2_r <= sb_s1_r;
      por_s1_r <= por_n_in;
      por_s2_r <= por_s1_r;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [3:0] overlay_r;           // ram_overlay_control
  logic [FPE_C1_W-1:0] ctrl1_r;    // flash_control_one
  logic flash_error_flag_r;                    // flash_error_flag
  logic [7:0] ebs1_r;              // erase_block_select_one
  logic [7:0] ebs2_r;              // erase_block_select_two
  logic boot_r;                    // Boot program running
  logic [31:0] vaddr_r;            // Verify address
  logic [31:0] paddr_r;            // Program start address
  logic [7:0] pcount_r;            // Bytes latched so far
  logic [7:0] pbuf_r [FPE_PROG_UNIT];  // Latched program data

  // APB decode
  logic apb_wr;
  logic apb_rd;
  logic hw_clear;
  logic overlay_select_bit;
  logic software_write_enable_bit;
  logic protect;
  logic busy;
  logic err_evt;

  assign apb_wr = psel_in && penable_in && pwrite_in;
  assign apb_rd = psel_in && penable_in && !pwrite_in;
  // Pin high, standby: initialise controls
  assign hw_clear = wp_s2_r || sb_s2_r;
  assign overlay_select_bit = overlay_r[FPE_OVL_OVERLAY_SELECT_BIT_BIT];
  assign software_write_enable_bit = ctrl1_r[FPE_C1_SWE_BIT];
  // Any protection stops program and erase entry
  assign protect = overlay_select_bit || !software_write_enable_bit || wp_s2_r || flash_error_flag_r;
  assign busy = ctrl1_r[FPE_C1_P_BIT] || ctrl1_r[FPE_C1_E_BIT];
  // Read, exception or sleep while busy is an error
  assign err_evt = busy && apb_wr && (paddr_in == FPE_OFS_EVENT) &&
    (pwdata_in[FPE_EV_READ_BIT] || pwdata_in[FPE_EV_EXC_BIT] ||
     pwdata_in[FPE_EV_SLEEP_BIT]);

  // Overlay register: cleared only by chip reset
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      overlay_r <= 4'h0;
    else if (apb_wr && paddr_in == FPE_OFS_OVERLAY)
      overlay_r <= pwdata_in[3:0];
  end

  // Control one: P and E enter from idle only when unprotected
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      ctrl1_r <= '0;
    else if (hw_clear)
      ctrl1_r <= '0;
    else if (err_evt)
    begin
      // Abort program/erase, keep verify and enable bits
      ctrl1_r[FPE_C1_P_BIT] <= 1'b0;
      ctrl1_r[FPE_C1_E_BIT] <= 1'b0;
    end
    else if (apb_wr && paddr_in == FPE_OFS_CTRL1)
    begin
      ctrl1_r <= pwdata_in[FPE_C1_W-1:0];
      // Block entry while protected
      // A write that drops write enable never starts a pulse
      if ((protect && !busy) || !pwdata_in[FPE_C1_SWE_BIT])
      begin
        ctrl1_r[FPE_C1_P_BIT] <= 1'b0;
        ctrl1_r[FPE_C1_E_BIT] <= 1'b0;
      end
    end
  end

  // Error flag: set wins; only power-on reset or chip reset clears
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      flash_error_flag_r <= 1'b0;
    else if (err_evt)
      flash_error_flag_r <= 1'b1;
    else if (!por_s2_r)
      flash_error_flag_r <= 1'b0;
  end

  // Erase block selects
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ebs1_r <= FPE_RST_BYTE;
      ebs2_r <= FPE_RST_BYTE;
    end
    else if (hw_clear)
    begin
      ebs1_r <= FPE_RST_BYTE;
      ebs2_r <= FPE_RST_BYTE;
    end
    else if (apb_wr && paddr_in == FPE_OFS_EBS1)
      ebs1_r <= pwdata_in[7:0];
    else if (apb_wr && paddr_in == FPE_OFS_EBS2)
      ebs2_r <= pwdata_in[7:0];
  end

  // Boot program level from software
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      boot_r <= 1'b0;
    else if (apb_wr && paddr_in == FPE_OFS_EVENT)
      boot_r <= pwdata_in[FPE_EV_BOOT_BIT];
  end

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  // Four modes from the control bits
  always_comb
  begin
    if (ctrl1_r[FPE_C1_P_BIT])
      mode_out = FPE_MODE_PROG;
    else if (ctrl1_r[FPE_C1_E_BIT])
      mode_out = FPE_MODE_ERASE;
    else if (ctrl1_r[FPE_C1_PV_BIT])
      mode_out = FPE_MODE_PVER;
    else if (ctrl1_r[FPE_C1_EV_BIT])
      mode_out = FPE_MODE_EVER;
    else
      mode_out = FPE_MODE_IDLE;
  end

  // Pulses last exactly as long as the bits
  assign prog_pulse_out = ctrl1_r[FPE_C1_P_BIT];
  // Erase acts on flash blocks only, never overlay RAM
  assign erase_pulse_out = ctrl1_r[FPE_C1_E_BIT];
  assign erase_blocks_out = {ebs2_r, ebs1_r};

  // Interrupts blocked during program, erase, boot
  assign irq_out = irq_in && !busy && !boot_r;
  assign nmi_out = nmi_in && !busy && !boot_r;

  // ----------------------------------------
  // Address overlay routing
  // ----------------------------------------
  logic in_ram_win;
  logic in_sel_blk;

  // Fixed 4-kbyte RAM window
  assign in_ram_win = (mem_req_in.addr >= FPE_OVL_RAM_BASE) &&
    (mem_req_in.addr <= FPE_OVL_RAM_LAST);
  // Selected small block among eight
  assign in_sel_blk = (mem_req_in.addr <= FPE_SMALL_BLK_LAST) &&
    (mem_req_in.addr[14:12] ==
     overlay_r[FPE_OVL_SEL_LSB +: FPE_OVL_SEL_W]);

  // RAM answers at both ranges while overlay on
  always_comb
  begin
    route_out.to_ram = 1'b0;
    route_out.addr = mem_req_in.addr;
    if (overlay_select_bit && in_sel_blk)
    begin
      route_out.to_ram = 1'b1;
      route_out.addr = {FPE_OVL_RAM_BASE[31:FPE_BLK_SHIFT],
                        mem_req_in.addr[FPE_BLK_SHIFT-1:0]};
    end
    else if (in_ram_win)
      route_out.to_ram = 1'b1;
  end

  // ----------------------------------------
  // Program latch and verify address
  // ----------------------------------------
  logic flash_wr;
  assign flash_wr = mem_req_in.valid && mem_req_in.write &&
    (mem_req_in.addr <= FPE_SMALL_BLK_LAST) && !route_out.to_ram;

  // Byte writes fill the 128-byte latch
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      paddr_r <= FPE_RST_WORD;
      pcount_r <= FPE_RST_BYTE;
    end
    else if (flash_wr && mode_out == FPE_MODE_IDLE && software_write_enable_bit)
    begin
      if (pcount_r == 8'h00 || pcount_r == 8'(FPE_PROG_UNIT))
      begin
        // Start address aligned to 00 or 80
        paddr_r <= {mem_req_in.addr[31:7], 7'h00};
        pcount_r <= 8'h01;
      end
      else
        pcount_r <= pcount_r + 8'h01;
    end
  end

  // Data bytes taken by low address bits
  always_ff @(posedge clk_in)
  begin
    if (flash_wr && mode_out == FPE_MODE_IDLE && software_write_enable_bit)
      pbuf_r[mem_req_in.addr[6:0]] <= mem_req_in.wdata[7:0];
  end

  assign prog_data_out = pbuf_r;
  assign prog_data_valid_out = (pcount_r == 8'(FPE_PROG_UNIT));

  // Dummy write of FF in verify mode picks read address
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      vaddr_r <= FPE_RST_WORD;
    else if (flash_wr && mem_req_in.wdata[7:0] == FPE_PAD_BYTE &&
             (mode_out == FPE_MODE_PVER || mode_out == FPE_MODE_EVER))
      vaddr_r <= {mem_req_in.addr[31:2], 2'b00};
  end

  // ----------------------------------------
  // APB read mux
  // ----------------------------------------
  always_comb
  begin
    prdata_out = '0;
    pslverr_out = 1'b0;
    if (apb_rd)
    begin
      case (paddr_in)
        FPE_OFS_OVERLAY: prdata_out = {28'h0, overlay_r};
        FPE_OFS_CTRL1: prdata_out = {25'h0, ctrl1_r};
        FPE_OFS_CTRL2: prdata_out = {24'h0, flash_error_flag_r, 7'h00};
        FPE_OFS_EBS1: prdata_out = {24'h0, ebs1_r};
        FPE_OFS_EBS2: prdata_out = {24'h0, ebs2_r};
        FPE_OFS_STATUS: prdata_out = {25'h0, protect, boot_r,
                                      prog_data_valid_out,
                                      1'b0, mode_out};
        FPE_OFS_VADDR: prdata_out = vaddr_r;
        FPE_OFS_PADDR: prdata_out = paddr_r;
        FPE_OFS_EVENT: prdata_out = {28'h0, boot_r, 3'b000};
        default: pslverr_out = 1'b1;  // Unmapped
      endcase
    end
  end

  // Zero wait states
  assign pready_out = 1'b1;

endmodule

/* test/fpe_chk_properties.sv */
`timescale 1ns/100ps
// ------------------------------
// Port checker
// ------------------------------
module fpe_chk
  import fpe_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Bus and pins
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic write_protect_pin_in,
  input wire logic standby_in,
  // Memory side and controls
  input wire fpe_mem_req_t mem_req_in,
  input wire fpe_route_t route_out,
  input wire logic prog_pulse_out,
  input wire logic erase_pulse_out,
  input wire logic [15:0] erase_blocks_out,
  input wire logic irq_out,
  input wire logic nmi_out,
  input wire fpe_mode_t mode_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // Write access phase to one register
  sequence s_wr(ofs);
    psel_in && penable_in && pwrite_in && paddr_in == ofs;
  endsequence
  property p_prog_stop;
    s_wr(FPE_OFS_CTRL1) ##0 !pwdata_in[FPE_C1_P_BIT] |=> !prog_pulse_out;
  endproperty
  a_prog_stop: assert property (p_prog_stop)
    else $error("program pulse outlived its enable");
  property p_erase_stop;
    s_wr(FPE_OFS_CTRL1) ##0 !pwdata_in[FPE_C1_E_BIT] |=> !erase_pulse_out;
  endproperty
  a_erase_stop: assert property (p_erase_stop)
    else $error("erase pulse outlived its enable");
  property p_mode;
    prog_pulse_out |-> mode_out == FPE_MODE_PROG;
  endproperty
  a_mode: assert property (p_mode)
    else $error("program pulse outside program mode");
  property p_irq_block;
    prog_pulse_out || erase_pulse_out |-> !irq_out && !nmi_out;
  endproperty
  a_irq_block: assert property (p_irq_block)
    else $error("interrupt passed during operation");
  property p_pin;
    write_protect_pin_in [*4] |=> !prog_pulse_out && !erase_pulse_out
      && erase_blocks_out == 16'h0000;
  endproperty
  a_pin: assert property (p_pin)
    else $error("protect pin did not clear controls");
  property p_stby;
    standby_in [*4] |=> !prog_pulse_out && !erase_pulse_out
      && erase_blocks_out == 16'h0000;
  endproperty
  a_stby: assert property (p_stby)
    else $error("standby did not clear controls");
  property p_swe;
    s_wr(FPE_OFS_CTRL1) ##0 (pwdata_in[FPE_C1_P_BIT]
      && !pwdata_in[FPE_C1_SWE_BIT] && !prog_pulse_out) |=> !prog_pulse_out;
  endproperty
  a_swe: assert property (p_swe)
    else $error("program entered without write enable");
  property p_err;
    s_wr(FPE_OFS_EVENT) ##0 (pwdata_in[2:0] != 3'h0 && prog_pulse_out)
      |=> !prog_pulse_out [*3];
  endproperty
  a_err: assert property (p_err)
    else $error("fault event did not abort program");
  property p_ram_hit;
    mem_req_in.valid && mem_req_in.addr >= FPE_OVL_RAM_BASE
      && mem_req_in.addr <= FPE_OVL_RAM_LAST
      |-> route_out.to_ram && route_out.addr == mem_req_in.addr;
  endproperty
  a_ram_hit: assert property (p_ram_hit)
    else $error("overlay RAM not reached at own address");
endmodule
bind fpe_flash_ctrl fpe_chk u_chk (.clk_in(clk_in), .arst_n_in(arst_n_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
  .paddr_in(paddr_in), .pwdata_in(pwdata_in), .standby_in(standby_in),
  .write_protect_pin_in(write_protect_pin_in), .mem_req_in(mem_req_in),
  .route_out(route_out), .prog_pulse_out(prog_pulse_out),
  .erase_pulse_out(erase_pulse_out), .erase_blocks_out(erase_blocks_out),
  .irq_out(irq_out), .nmi_out(nmi_out), .mode_out(mode_out));

/* test/fpe_cpu_model.sv */
`timescale 1ns/100ps
// ------------------------------
// CPU side memory traffic
// ------------------------------
module fpe_cpu_model
  import fpe_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Request towards the block
  output fpe_mem_req_t mem_req_out
);
  initial mem_req_out = '0;
  // One byte write per cycle, lane from the low address bits
  task automatic put_byte(input logic [31:0] a, input logic [7:0] d);
    @(posedge clk_in);
    mem_req_out <= {1'b1, 1'b1, 4'h1 << a[1:0], a, {4{d}}};
  endtask
  // Release; stale address and data are inverted so they never match
  task automatic idle();
    @(posedge clk_in);
    mem_req_out <= {2'b00, 4'h0, ~mem_req_out.addr, ~mem_req_out.wdata};
  endtask
  // Whole unit from an aligned start, unused bytes padded
  task automatic send_unit(input logic [31:0] base, input int n);
    for (int i = 0; i < FPE_PROG_UNIT; i++)
      put_byte(base + 32'(i), (i < n) ? 8'(i) ^ 8'h5A : FPE_PAD_BYTE);
    idle();
  endtask
endmodule

/* test/flash_program_erase_emulation_tb_top.sv */
`timescale 1ns/100ps
// ------------------------------
// Bench top
// ------------------------------
module flash_program_erase_emulation_tb_top
  import fpe_pkg::*;
;
  logic clk_in, arst_n_in, psel_in, penable_in, pwrite_in, pready_out;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  logic pslverr_out, perr, write_protect_pin_in, standby_in, por_n_in;
  logic irq_in, nmi_in, irq_out, nmi_out, prog_pulse_out, erase_pulse_out;
  logic prog_data_valid_out;
  logic [15:0] erase_blocks_out;
  logic [7:0] prog_data_out [FPE_PROG_UNIT];
  fpe_mem_req_t mem_req_in;
  fpe_route_t route_out;
  fpe_mode_t mode_out;
  logic [11:0] rst_ofs [4] = '{FPE_OFS_OVERLAY, FPE_OFS_CTRL1,
    FPE_OFS_EBS1, FPE_OFS_EBS2};
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  fpe_flash_ctrl uut (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .write_protect_pin_in(write_protect_pin_in), .standby_in(standby_in),
    .por_n_in(por_n_in), .mem_req_in(mem_req_in), .route_out(route_out),
    .prog_pulse_out(prog_pulse_out), .erase_pulse_out(erase_pulse_out),
    .erase_blocks_out(erase_blocks_out), .prog_data_out(prog_data_out),
    .prog_data_valid_out(prog_data_valid_out), .irq_in(irq_in),
    .nmi_in(nmi_in), .irq_out(irq_out), .nmi_out(nmi_out),
    .mode_out(mode_out));
  fpe_cpu_model cpu (.clk_in(clk_in), .mem_req_out(mem_req_in));
  // Clock
  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  // Hang guard
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_count++;
      give_verdict();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // APB transfer; returns settled at the following falling edge
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    // Wait for pready; only the hang guard ends a stuck wait
    do
      @(posedge clk_in);
    while (pready_out !== 1'b1);
    rd = prdata_out;
    perr = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(negedge clk_in);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd & m, exp);
  endtask
  task automatic wait_edges(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
    {arst_n_in, write_protect_pin_in, standby_in, por_n_in} = '0;
    {irq_in, nmi_in} = 2'b11;
    wait_edges(4);
    arst_n_in <= 1'b1;
    por_n_in <= 1'b1;
    wait_edges(3);
    foreach (rst_ofs[i])
      rdc(rst_ofs[i], 32'hFFFF_FFFF, FPE_RST_WORD);
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    check({31'h0, perr}, 32'h1);
    $display("test reset done");
    apb(1'b1, FPE_OFS_CTRL1, 32'h0000_0001);
    check({31'h0, prog_pulse_out}, 32'h0);
    apb(1'b1, FPE_OFS_CTRL1, 32'h0000_0040);
    cpu.send_unit(32'h0000_1080, 64);
    @(negedge clk_in);
    check({31'h0, prog_data_valid_out}, 32'h1);
    for (int i = 0; i < FPE_PROG_UNIT; i++)
      check({24'h0, prog_data_out[i]},
        {24'h0, i < 64 ? 8'(i) ^ 8'h5A : FPE_PAD_BYTE});
    rdc(FPE_OFS_PADDR, 32'hFFFF_FFFF, 32'h0000_1080);
    apb(1'b1, FPE_OFS_CTRL1, 32'h0000_0041);
    check({31'h0, prog_pulse_out}, 32'h1);
    check({30'h0, irq_out, nmi_out}, 32'h0);
    check({29'h0, mode_out}, {29'h0, FPE_MODE_PROG});
    apb(1'b1, FPE_OFS_CTRL1, 32'h0000_0040);
    check({31'h0, prog_pulse_out}, 32'h0);
    check({30'h0, irq_out, nmi_out}, 32'h3);
    apb(1'b1, FPE_OFS_CTRL1, 32'h0000_0044);
    check({29'h0, mode_out}, {29'h0, FPE_MODE_PVER});
    cpu.put_byte(32'h0000_1086, FPE_PAD_BYTE);
    cpu.idle();
    rdc(FPE_OFS_VADDR, 32'hFFFF_FFFF, 32'h0000_1084);
    apb(1'b1, FPE_OFS_CTRL1, 32'h0000_0048);
    check({29'h0, mode_out}, {29'h0, FPE_MODE_EVER});
    $display("test program done");
    apb(1'b1, FPE_OFS_EBS1, 32'h0000_0002);
    apb(1'b1, FPE_OFS_CTRL1, 32'h0000_0042);
    check({31'h0, erase_pulse_out}, 32'h1);
    check({16'h0, erase_blocks_out}, 32'h0000_0002);
    check({29'h0, mode_out}, {29'h0, FPE_MODE_ERASE});
    apb(1'b1, FPE_OFS_CTRL1, 32'h0000_0040);
    check({31'h0, erase_pulse_out}, 32'h0);
    apb(1'b1, FPE_OFS_EVENT, 32'h0000_0008);
    check({30'h0, irq_out, nmi_out}, 32'h0);
    apb(1'b1, FPE_OFS_EVENT, 32'h0000_0000);
    check({30'h0, irq_out, nmi_out}, 32'h3);
    $display("test erase done");
    apb(1'b1, FPE_OFS_OVERLAY, 32'h0000_000B);
    apb(1'b1, FPE_OFS_CTRL1, 32'h0000_0041);
    check({31'h0, prog_pulse_out}, 32'h0);
    cpu.put_byte(32'h0000_3010, FPE_PAD_BYTE);
    @(negedge clk_in);
    check({31'h0, route_out.to_ram}, 32'h1);
    check(route_out.addr, 32'hFFFF_D010);
    cpu.put_byte(32'h0000_4010, FPE_PAD_BYTE);
    @(negedge clk_in);
    check({31'h0, route_out.to_ram}, 32'h0);
    cpu.put_byte(32'hFFFF_DFFC, FPE_PAD_BYTE);
    @(negedge clk_in);
    check({31'h0, route_out.to_ram}, 32'h1);
    cpu.idle();
    apb(1'b1, FPE_OFS_OVERLAY, 32'h0000_0000);
    $display("test overlay done");
    apb(1'b1, FPE_OFS_CTRL1, 32'h0000_0041);
    apb(1'b1, FPE_OFS_EVENT, 32'h0000_0001);
    check({31'h0, prog_pulse_out}, 32'h0);
    rdc(FPE_OFS_CTRL2, 32'h0000_0080, 32'h0000_0080);
    apb(1'b1, FPE_OFS_CTRL1, 32'h0000_0041);
    check({31'h0, prog_pulse_out}, 32'h0);
    @(posedge clk_in);
    por_n_in <= 1'b0;
    wait_edges(4);
    por_n_in <= 1'b1;
    wait_edges(4);
    rdc(FPE_OFS_CTRL2, 32'h0000_0080, 32'h0000_0000);
    $display("test error done");
    apb(1'b1, FPE_OFS_CTRL1, 32'h0000_0041);
    @(posedge clk_in);
    write_protect_pin_in <= 1'b1;
    wait_edges(6);
    rdc(FPE_OFS_CTRL1, 32'hFFFF_FFFF, FPE_RST_WORD);
    @(posedge clk_in);
    write_protect_pin_in <= 1'b0;
    wait_edges(3);
    apb(1'b1, FPE_OFS_EBS1, 32'h0000_0002);
    apb(1'b1, FPE_OFS_CTRL1, 32'h0000_0040);
    apb(1'b1, FPE_OFS_CTRL1, 32'h0000_0042);
    check({31'h0, erase_pulse_out}, 32'h1);
    @(posedge clk_in);
    standby_in <= 1'b1;
    wait_edges(6);
    rdc(FPE_OFS_EBS1, 32'hFFFF_FFFF, FPE_RST_WORD);
    check({31'h0, erase_pulse_out}, 32'h0);
    @(posedge clk_in);
    standby_in <= 1'b0;
    $display("test protect done");
    give_verdict();
  end
endmodule
